// File: verilog/bridge_uart_pkg.sv
// shared constants and carriers for the bridged serial port core
package bridge_uart_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] REG_BAUD = 8'h04;
    localparam logic [ADDR_W-1:0] REG_LINE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_PINCFG = 8'h10;
    // clock figures in MHz
    localparam int SYS_CLK_MHZ = 125;
    localparam int REF_CLK_MHZ = 48;
    localparam logic [7:0] REF_STEP = 8'(REF_CLK_MHZ);
    localparam logic [7:0] REF_WRAP = 8'(SYS_CLK_MHZ);
    // baud divisor, in eighths
    localparam int DIV_INT_W = 14;
    localparam int DIV_FRAC_W = 3;
    localparam int DIV_ACC_W = 18;
    localparam logic [DIV_ACC_W-1:0] DIV_EIGHTH_STEP = 18'h00008;
    localparam logic [DIV_INT_W:0] DIV_INT_MAX = 15'h4000;
    localparam logic [DIV_INT_W:0] DIV_INT_ONE = 15'h0001;
    localparam logic [DIV_INT_W+DIV_FRAC_W-1:0] BAUD_RST = 17'h00008;
    localparam int FRAC_POS = 14;
    // bit timing in 16x ticks
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_HALF = 4'h7;
    localparam logic [2:0] LAST_BIT8 = 3'h7;
    localparam logic [2:0] LAST_BIT7 = 3'h6;
    localparam int H2L_AW = 7;
    localparam int L2H_AW = 8;
    localparam logic [L2H_AW:0] L2H_HIGH_MARK = 9'h0E0;
    // software flow characters
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    // pin index for inversion and drive strength
    localparam int PIN_N = 8;
    localparam int PIN_TXD = 0;
    localparam int PIN_RXD = 1;
    localparam int PIN_RTS = 2;
    localparam int PIN_CTS = 3;
    localparam int PIN_DTR = 4;
    localparam int PIN_DSR = 5;
    localparam int PIN_DCD = 6;
    localparam int PIN_RI = 7;
    localparam int ST_BRK = 2;
    localparam int ST_FRM = 3;
    typedef enum logic [1:0] {
        FLOW_NONE = 2'h0, FLOW_RTSCTS = 2'h1, FLOW_DTRDSR = 2'h2, FLOW_XONXOFF = 2'h3
    } flow_mode_t;
    typedef enum logic [1:0] {
        REF_48 = 2'h0, REF_24 = 2'h1, REF_12 = 2'h2, REF_6 = 2'h3
    } ref_sel_t;
    typedef enum logic [1:0] {
        LS_IDLE = 2'b00, LS_START = 2'b01, LS_DATA = 2'b11, LS_STOP = 2'b10
    } line_state_t;
    typedef struct packed {
        ref_sel_t ref_sel;
        logic drv_en_opt;
        logic dtr;
        logic rts;
        logic brk;
        flow_mode_t flow;
        logic char8;
    } line_ctrl_t;
    localparam line_ctrl_t LINE_RST = 9'h001;
    typedef struct packed {
        logic [PIN_N-1:0] invert;
        logic [PIN_N-1:0] drive_high;
    } pin_cfg_t;
endpackage : bridge_uart_pkg

// File: verilog/bridge_uart_core.sv
// serial port core of a usb bridge: baud generator, fifos, line controller
// Behaviour
// RULE1: bit timing uses a 16x enable derived from the 48 MHz reference.
// RULE2: divisor is 14-bit integer plus three fraction bits.
// RULE3: bit rate is 3000000 over n plus x, n from 2 to 16384.
// RULE4: fraction is a multiple of one eighth, zero to 0.875.
// RULE5: divisor one with zero fraction allowed; between one and two not.
// RULE6: host bytes queue in 128-byte buffer, moved in order to transmitter.
// RULE7: received characters queue in 256 bytes, delivered only when host reads.
// RULE8: transmitter and receiver handle seven or eight data bits.
// RULE9: drive RTS and DTR, sample CTS, DSR, DCD and RI.
// RULE10: optional line driver enable output for RS485 transceivers.
// RULE11: hardware flow control by RTS/CTS, DSR/DTR or XON/XOFF.
// RULE12: force break on command and detect received break.
// RULE13: each pin has inversion and drive strength from nonvolatile setup.
// RULE14: 12 MHz reference paces the fifo controller.
// RULE15: 48 MHz reference made, divided to 24, 12 and 6 MHz.
// RULE16: reset at power-up or by active-low external reset input.
// RULE17: host control commands set divisor, format and handshake mode.
// RULE18: driver enable option turns a control pin into transmit enable.
// RULE19: start bit low, lsb first, high stop bit, idle high.
// RULE20: receiver checks start at mid bit, samples each bit centre.
// RULE21: driver enable held from first start bit to last stop bit.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter int AW = 7
) (
    input wire logic clk_in, // clock
    input wire logic rst_n_in, // async reset
    input wire logic push_in, // write one byte
    input wire logic [7:0] data_in, // byte written
    input wire logic pop_in, // drop head byte
    output logic [7:0] data_out, // head byte
    output logic full_out, // no room
    output logic empty_out, // nothing stored
    output logic [AW:0] level_out // bytes stored
);
    logic [7:0] mem_q [2**AW];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic do_push;
    logic do_pop;

    assign full_out = cnt_q[AW];
    assign empty_out = (cnt_q == '0);
    assign level_out = cnt_q;
    assign data_out = mem_q[rd_q];
    assign do_push = push_in && !full_out;
    assign do_pop = pop_in && !empty_out;

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem_q[wr_q] <= data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule // byte_fifo

module bridge_uart_core (
    input wire logic sys_clk_in, // 125 MHz clock
    input wire logic reset_n_in, // power-on reset, active low
    input wire logic ext_reset_n_in, // external reset pin, active low
    input wire logic [bridge_uart_pkg::ADDR_W-1:0] addr_in, // register address
    input wire logic [bridge_uart_pkg::DATA_W-1:0] wr_data_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [bridge_uart_pkg::DATA_W-1:0] rd_data_out, // read data, next cycle
    input wire bridge_uart_pkg::pin_cfg_t nv_cfg_in, // nonvolatile pin setup
    input wire logic rxd_in, // serial input
    input wire logic cts_n_in, // clear to send
    input wire logic dsr_n_in, // data set ready
    input wire logic dcd_n_in, // carrier detect
    input wire logic ri_n_in, // ring indicator
    output logic txd_out, // serial output
    output logic rts_n_out, // request to send
    output logic dtr_n_out, // data terminal ready
    output logic line_driver_enable_out, // rs485 transmit enable
    output logic [bridge_uart_pkg::PIN_N-1:0] drive_high_out, // per pin high drive
    output logic ref_tick_out // selected reference enable
);
    import bridge_uart_pkg::*;

    logic core_rst_n;
    // RULE16 either source resets
    assign core_rst_n = reset_n_in & ext_reset_n_in;

    line_ctrl_t line_q;
    logic [DIV_INT_W+DIV_FRAC_W-1:0] baud_q;
    pin_cfg_t pin_q;
    logic cfg_loaded_q;

    logic [7:0] ref_acc_q;
    logic tick48_q;
    logic [2:0] ref_div_q;
    logic tick12;
    logic ref_sel_tick;
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            ref_acc_q <= '0;
            tick48_q <= 1'b0;
            ref_div_q <= '0;
            ref_tick_out <= 1'b0;
        end else begin
            // RULE15 48 MHz enable
            if (ref_acc_q + REF_STEP >= REF_WRAP) begin
                ref_acc_q <= ref_acc_q + REF_STEP - REF_WRAP;
                tick48_q <= 1'b1;
            end else begin
                ref_acc_q <= ref_acc_q + REF_STEP;
                tick48_q <= 1'b0;
            end
            if (tick48_q) begin
                ref_div_q <= ref_div_q + 1'b1;
            end
            ref_tick_out <= ref_sel_tick;
        end
    end
    // RULE15 24, 12, 6 MHz
    always_comb begin
        unique case (line_q.ref_sel)
            REF_48: ref_sel_tick = tick48_q;
            REF_24: ref_sel_tick = tick48_q && ref_div_q[0];
            REF_12: ref_sel_tick = tick12;
            REF_6: ref_sel_tick = tick48_q && (ref_div_q == 3'h7);
        endcase
    end
    assign tick12 = tick48_q && (ref_div_q[1:0] == 2'h3);

    logic [DIV_INT_W:0] div_int;
    logic [DIV_FRAC_W-1:0] div_frac;
    logic [DIV_ACC_W-1:0] div_eighths;
    logic [DIV_ACC_W-1:0] baud_acc_q;
    logic tick16;
    always_comb begin
        // RULE3 zero field means 16384
        div_int = (baud_q[DIV_INT_W-1:0] == '0) ? DIV_INT_MAX : {1'b0, baud_q[DIV_INT_W-1:0]};
        // RULE4 eighths
        div_frac = baud_q[FRAC_POS +: DIV_FRAC_W];
        // RULE5 n one, no fraction
        if (div_int == DIV_INT_ONE) begin
            div_frac = '0;
        end
        // RULE2 integer plus fraction
        div_eighths = {div_int, {DIV_FRAC_W{1'b0}}} + DIV_ACC_W'(div_frac);
    end
    // RULE1 16x enable from 48 MHz
    assign tick16 = tick48_q && (baud_acc_q + DIV_EIGHTH_STEP >= div_eighths);
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            baud_acc_q <= '0;
        end else if (tick16) begin
            baud_acc_q <= baud_acc_q + DIV_EIGHTH_STEP - div_eighths;
        end else if (tick48_q) begin
            baud_acc_q <= baud_acc_q + DIV_EIGHTH_STEP;
        end
    end

    logic h2l_push, h2l_pop, h2l_full, h2l_empty;
    logic [7:0] h2l_data;
    logic l2h_push, l2h_pop, l2h_full, l2h_empty;
    logic [7:0] l2h_data, rx_char;
    logic [L2H_AW:0] l2h_level;
    logic wr_data_reg, rd_data_reg;
    assign wr_data_reg = wr_in && (addr_in == REG_DATA);
    assign rd_data_reg = rd_in && (addr_in == REG_DATA);
    // RULE6 host bytes queued
    assign h2l_push = wr_data_reg;
    // RULE7 popped only by host read
    assign l2h_pop = rd_data_reg;

    byte_fifo #(.AW(H2L_AW)) h2l_fifo (
        .clk_in(sys_clk_in), .rst_n_in(core_rst_n), .push_in(h2l_push),
        .data_in(wr_data_in[7:0]), .pop_in(h2l_pop), .data_out(h2l_data),
        .full_out(h2l_full), .empty_out(h2l_empty), .level_out()
    );
    byte_fifo #(.AW(L2H_AW)) l2h_fifo (
        .clk_in(sys_clk_in), .rst_n_in(core_rst_n), .push_in(l2h_push),
        .data_in(rx_char), .pop_in(l2h_pop), .data_out(l2h_data),
        .full_out(l2h_full), .empty_out(l2h_empty), .level_out(l2h_level)
    );

    logic rxd_act, cts_act, dsr_act, dcd_act, ri_act;
    // RULE13 per pin inversion
    assign rxd_act = rxd_in ^ pin_q.invert[PIN_RXD];
    // RULE9 modem status sampled
    assign cts_act = ~(cts_n_in ^ pin_q.invert[PIN_CTS]);
    assign dsr_act = ~(dsr_n_in ^ pin_q.invert[PIN_DSR]);
    assign dcd_act = ~(dcd_n_in ^ pin_q.invert[PIN_DCD]);
    assign ri_act = ~(ri_n_in ^ pin_q.invert[PIN_RI]);

    line_state_t tx_st_q;
    logic [3:0] tx_cnt_q;
    logic [2:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic [7:0] hold_q;
    logic hold_valid_q;
    logic xoff_q;
    logic tx_permit, tx_start, tx_line;
    logic [2:0] last_bit;
    assign last_bit = line_q.char8 ? LAST_BIT8 : LAST_BIT7;
    // RULE11 flow permit
    always_comb begin
        unique case (line_q.flow)
            FLOW_NONE: tx_permit = 1'b1;
            FLOW_RTSCTS: tx_permit = cts_act;
            FLOW_DTRDSR: tx_permit = dsr_act;
            FLOW_XONXOFF: tx_permit = !xoff_q;
        endcase
    end
    assign tx_start = (tx_st_q == LS_IDLE) && hold_valid_q && tx_permit && !line_q.brk;
    // RULE14 12 MHz pacing
    assign h2l_pop = tick12 && !hold_valid_q && !h2l_empty;

    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            hold_q <= '0;
            hold_valid_q <= 1'b0;
        end else if (h2l_pop) begin
            // RULE6 in-order load
            hold_q <= h2l_data;
            hold_valid_q <= 1'b1;
        end else if (tx_start) begin
            hold_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            tx_st_q <= LS_IDLE;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= '0;
        end else if (tx_start) begin
            tx_st_q <= LS_START;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= hold_q;
        end else if (tick16 && tx_st_q != LS_IDLE) begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
            if (tx_cnt_q == TICK_LAST) begin
                unique case (tx_st_q)
                    LS_START: tx_st_q <= LS_DATA;
                    // RULE8 seven or eight bits
                    LS_DATA: begin
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 1'b1;
                        if (tx_bit_q == last_bit) begin
                            tx_st_q <= LS_STOP;
                        end
                    end
                    LS_STOP: tx_st_q <= LS_IDLE;
                    default: tx_st_q <= LS_IDLE;
                endcase
            end
        end
    end
    // RULE19 framing, lsb first
    always_comb begin
        unique case (tx_st_q)
            LS_START: tx_line = 1'b0;
            LS_DATA: tx_line = tx_sh_q[0];
            default: tx_line = 1'b1;
        endcase
        // RULE12 forced break
        if (line_q.brk) begin
            tx_line = 1'b0;
        end
    end

    line_state_t rx_st_q;
    logic [3:0] rx_cnt_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_done, rx_ok, brk_set, frm_set, is_flow_char;
    assign rx_done = tick16 && (rx_st_q == LS_STOP) && (rx_cnt_q == TICK_LAST);
    assign rx_char = line_q.char8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
    assign rx_ok = rx_done && rxd_act;
    assign is_flow_char = (line_q.flow == FLOW_XONXOFF)
        && (rx_char == XON_CHAR || rx_char == XOFF_CHAR);
    // RULE7 queue received characters
    assign l2h_push = rx_ok && !is_flow_char;
    // RULE12 break detect
    assign brk_set = rx_done && !rxd_act && (rx_char == '0);
    assign frm_set = rx_done && !rxd_act && (rx_char != '0);

    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            rx_st_q <= LS_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
        end else if (rx_st_q == LS_IDLE) begin
            if (!rxd_act) begin
                rx_st_q <= LS_START;
                rx_cnt_q <= '0;
            end
        end else if (tick16) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
            unique case (rx_st_q)
                // RULE20 confirm start at mid bit
                LS_START: if (rx_cnt_q == TICK_HALF) begin
                    rx_cnt_q <= '0;
                    rx_bit_q <= '0;
                    rx_st_q <= rxd_act ? LS_IDLE : LS_DATA;
                end
                // RULE20 sample bit centres
                LS_DATA: if (rx_cnt_q == TICK_LAST) begin
                    rx_sh_q <= {rxd_act, rx_sh_q[7:1]};
                    rx_bit_q <= rx_bit_q + 1'b1;
                    if (rx_bit_q == last_bit) begin
                        rx_st_q <= LS_STOP;
                    end
                end
                LS_STOP: if (rx_cnt_q == TICK_LAST) begin
                    rx_st_q <= LS_IDLE;
                end
                default: rx_st_q <= LS_IDLE;
            endcase
        end
    end

    // RULE11 software flow state
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            xoff_q <= 1'b0;
        end else if (line_q.flow != FLOW_XONXOFF) begin
            xoff_q <= 1'b0;
        end else if (rx_ok && rx_char == XOFF_CHAR) begin
            xoff_q <= 1'b1;
        end else if (rx_ok && rx_char == XON_CHAR) begin
            xoff_q <= 1'b0;
        end
    end

    // sticky flags, set wins over clear
    logic brk_seen_q, frm_err_q, st_clr;
    assign st_clr = wr_in && (addr_in == REG_STATUS);
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            brk_seen_q <= 1'b0;
            frm_err_q <= 1'b0;
        end else begin
            brk_seen_q <= brk_set || (brk_seen_q && !(st_clr && wr_data_in[ST_BRK]));
            frm_err_q <= frm_set || (frm_err_q && !(st_clr && wr_data_in[ST_FRM]));
        end
    end

    logic rx_room, rts_act, dtr_act, de_q;
    assign rx_room = (l2h_level < L2H_HIGH_MARK);
    // RULE11 hardware handshake outputs
    assign rts_act = line_q.rts && (line_q.flow != FLOW_RTSCTS || rx_room);
    assign dtr_act = line_q.dtr && (line_q.flow != FLOW_DTRDSR || rx_room);
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            de_q <= 1'b0;
        end else if (!line_q.drv_en_opt) begin
            de_q <= 1'b0;
        // RULE21 up from start bit
        end else if (tx_start) begin
            de_q <= 1'b1;
        // RULE21 down after last stop
        end else if (tick16 && tx_st_q == LS_STOP && tx_cnt_q == TICK_LAST
                     && !hold_valid_q && h2l_empty) begin
            de_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            txd_out <= 1'b1;
            rts_n_out <= 1'b1;
            dtr_n_out <= 1'b1;
            line_driver_enable_out <= 1'b0;
        end else begin
            // RULE13 output inversion
            txd_out <= tx_line ^ pin_q.invert[PIN_TXD];
            // RULE9 modem control outputs
            rts_n_out <= ~rts_act ^ pin_q.invert[PIN_RTS];
            dtr_n_out <= ~dtr_act ^ pin_q.invert[PIN_DTR];
            // RULE10 RULE18 driver enable pin
            line_driver_enable_out <= de_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            pin_q <= '0;
            cfg_loaded_q <= 1'b0;
            drive_high_out <= '0;
        end else begin
            // RULE13 load pin setup
            if (!cfg_loaded_q) begin
                pin_q <= nv_cfg_in;
                cfg_loaded_q <= 1'b1;
            end
            drive_high_out <= pin_q.drive_high;
        end
    end
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            line_q <= LINE_RST;
            baud_q <= BAUD_RST;
        // RULE17 host settings
        end else if (wr_in && addr_in == REG_LINE) begin
            line_q <= wr_data_in[$bits(line_ctrl_t)-1:0];
        end else if (wr_in && addr_in == REG_BAUD) begin
            baud_q <= wr_data_in[DIV_INT_W+DIV_FRAC_W-1:0];
        end
    end
    always_ff @(posedge sys_clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            rd_data_out <= '0;
        end else if (rd_in) begin
            unique case (addr_in)
                REG_DATA: rd_data_out <= {24'h000000, l2h_empty ? 8'h00 : l2h_data};
                REG_BAUD: rd_data_out <= DATA_W'(baud_q);
                REG_LINE: rd_data_out <= DATA_W'(line_q);
                REG_STATUS: rd_data_out <= DATA_W'({xoff_q, tx_st_q != LS_IDLE, ri_act,
                    dcd_act, dsr_act, cts_act, frm_err_q, brk_seen_q, h2l_full, !l2h_empty});
                REG_PINCFG: rd_data_out <= DATA_W'(pin_q);
                default: rd_data_out <= '0;
            endcase
        end else begin
            rd_data_out <= '0;
        end
    end
endmodule // bridge_uart_core

`default_nettype wire

// File: testbench/line_partner.sv
// serial line partner: loopback with modem lines crossed
`timescale 1ns/1ps
`default_nettype none
module line_partner (
    input wire logic txd_in, // device serial out
    input wire logic rts_n_in, // device request to send
    input wire logic dtr_n_in, // device terminal ready
    input wire logic hold_in, // keep clear to send inactive
    input wire logic [1:0] aux_n_in, // carrier and ring levels
    output logic rxd_out, // device serial in
    output logic cts_n_out, // clear to send
    output logic dsr_n_out, // data set ready
    output logic dcd_n_out, // carrier detect
    output logic ri_n_out // ring indicator
);
    assign rxd_out = txd_in;
    assign cts_n_out = rts_n_in | hold_in;
    assign dsr_n_out = dtr_n_in;
    assign {dcd_n_out, ri_n_out} = aux_n_in;
endmodule // line_partner
`default_nettype wire

// File: testbench/bridge_uart_monitor.sv
// assertion checker on the serial core ports
`timescale 1ns/1ps
`default_nettype none
module bridge_uart_monitor (
    input wire logic sys_clk_in, // clock
    input wire logic reset_n_in, // power-on reset
    input wire logic ext_reset_n_in, // external reset
    input wire logic [bridge_uart_pkg::ADDR_W-1:0] addr_in, // address
    input wire logic rd_in, // read strobe
    input wire logic [bridge_uart_pkg::DATA_W-1:0] rd_data_out, // read data
    input wire bridge_uart_pkg::pin_cfg_t nv_cfg_in, // pin setup
    input wire logic txd_out, // serial out
    input wire logic line_driver_enable_out, // driver enable
    input wire logic [bridge_uart_pkg::PIN_N-1:0] drive_high_out, // drive strength
    input wire logic ref_tick_out // reference enable
);
    import bridge_uart_pkg::*;
    logic rst_n;
    logic inv0;
    logic [1:0] up_q;
    assign rst_n = reset_n_in & ext_reset_n_in;
    assign inv0 = nv_cfg_in.invert[PIN_TXD];
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);
    sequence start_low;
        !txd_out [*8] ##1 !txd_out [*8] ##1 !txd_out [*8];
    endsequence
    rd_idle_a: assert property (!$past(rd_in) |-> rd_data_out == '0)
        else $error("read data outside its slot");
    pin_read_a: assert property (up_q == 2'h3 && rd_in && addr_in == REG_PINCFG
        |=> rd_data_out == 32'(nv_cfg_in)) else $error("pin setup readback wrong");
    drive_copy_a: assert property (up_q == 2'h3 |-> drive_high_out == nv_cfg_in.drive_high)
        else $error("drive strength not applied");
    bit_hold_a: assert property ($changed(txd_out) |=> $stable(txd_out) [*8])
        else $error("serial bit too short");
    start_low_a: assert property ($fell(txd_out) && !inv0 |-> start_low)
        else $error("start bit too short");
    tick_pulse_a: assert property (ref_tick_out |=> !ref_tick_out)
        else $error("reference enable too long");
    tick_gap_a: assert property ($fell(ref_tick_out) |-> ##[1:22] ref_tick_out)
        else $error("reference enable missing");
    drv_fall_a: assert property ($fell(line_driver_enable_out) |-> txd_out != inv0)
        else $error("driver enable dropped in a frame");
    drv_rise_a: assert property ($rose(line_driver_enable_out) |-> ##[0:2] txd_out == inv0)
        else $error("driver enable without start bit");
endmodule // bridge_uart_monitor
bind bridge_uart_core bridge_uart_monitor u_bridge_uart_monitor (.sys_clk_in, .reset_n_in,
    .ext_reset_n_in, .addr_in, .rd_in, .rd_data_out, .nv_cfg_in, .txd_out,
    .line_driver_enable_out, .drive_high_out, .ref_tick_out);
`default_nettype wire

// File: testbench/bridge_uart_core_bench.sv
// self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module bridge_uart_core_bench;
    import bridge_uart_pkg::*;
    logic sys_clk_in = 1'b0, reset_n_in = 1'b0, ext_reset_n_in = 1'b1;
    logic wr_in = 1'b0, rd_in = 1'b0, hold = 1'b0;
    logic [1:0] aux_n = 2'b11;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wr_data_in = '0, rd_data_out, rdv;
    pin_cfg_t nv_cfg_in = 16'h80A5;
    logic rxd_in, cts_n_in, dsr_n_in, dcd_n_in, ri_n_in, txd_out, rts_n_out, dtr_n_out;
    logic line_driver_enable_out, ref_tick_out;
    logic [PIN_N-1:0] drive_high_out;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    bridge_uart_core u_bridge_uart_core (.sys_clk_in, .reset_n_in, .ext_reset_n_in, .addr_in,
        .wr_data_in, .wr_in, .rd_in, .rd_data_out, .nv_cfg_in, .rxd_in, .cts_n_in, .dsr_n_in,
        .dcd_n_in, .ri_n_in, .txd_out, .rts_n_out, .dtr_n_out, .line_driver_enable_out,
        .drive_high_out, .ref_tick_out);
    line_partner u_line_partner (.txd_in(txd_out), .rts_n_in(rts_n_out), .dtr_n_in(dtr_n_out),
        .hold_in(hold), .aux_n_in(aux_n), .rxd_out(rxd_in), .cts_n_out(cts_n_in),
        .dsr_n_out(dsr_n_in), .dcd_n_out(dcd_n_in), .ri_n_out(ri_n_in));
    initial begin
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 rdv = rd_data_out;
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, e);
        rd(a);
        chk(rdv & m, e);
    endtask
    task automatic await(input int b, input logic v);
        int n = 0;
        rd(REG_STATUS);
        while (rdv[b] !== v && n < 3000) begin
            rd(REG_STATUS);
            n++;
        end
        chk(32'(rdv[b]), 32'(v));
    endtask
    task automatic till(input logic v, input int lim, output int n);
        for (n = 0; n < lim && txd_out !== v; n++) @(posedge sys_clk_in);
    endtask
    initial begin
        int n;
        repeat (12) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        rchk(REG_BAUD, '1, 32'h8);
        rchk(REG_LINE, '1, 32'h1);
        rchk(REG_PINCFG, '1, 32'h80A5);
        rchk(8'h40, '1, 32'h0);
        wr(REG_BAUD, 32'h1C005);
        rchk(REG_BAUD, '1, 32'h1C005);
        wr(REG_DATA, 32'h0);
        till(1'b0, 500, n);
        till(1'b1, 3000, n);
        chk(32'(n > 2183 && n < 2223), 32'h1);
        await(0, 1'b1);
        rchk(REG_DATA, '1, 32'h0);
        wr(REG_BAUD, 32'h1);
        wr(REG_LINE, 32'h41);
        wr(REG_DATA, 32'hA5);
        wr(REG_DATA, 32'h3C);
        till(1'b0, 500, n);
        for (n = 0; n < 2000 && line_driver_enable_out === 1'b1; n++) @(posedge sys_clk_in);
        chk(32'(n > 821 && n < 845), 32'h1);
        await(0, 1'b1);
        rchk(REG_DATA, '1, 32'hA5);
        rchk(REG_DATA, '1, 32'h3C);
        rchk(REG_DATA, '1, 32'h0);
        wr(REG_LINE, 32'h0);
        wr(REG_DATA, 32'hFF);
        till(1'b0, 500, n);
        chk(32'(line_driver_enable_out), 32'h0);
        await(0, 1'b1);
        rchk(REG_DATA, '1, 32'h7F);
        wr(REG_LINE, 32'h31);
        rchk(REG_STATUS, 32'hF0, 32'hB0);
        aux_n <= 2'b00;
        wr(REG_LINE, 32'h01);
        rchk(REG_STATUS, 32'hF0, 32'h40);
        hold <= 1'b1;
        wr(REG_LINE, 32'h13);
        wr(REG_DATA, 32'h5A);
        repeat (600) @(posedge sys_clk_in);
        rchk(REG_STATUS, 32'h1, 32'h0);
        hold <= 1'b0;
        await(0, 1'b1);
        rchk(REG_DATA, '1, 32'h5A);
        wr(REG_LINE, 32'h07);
        wr(REG_DATA, 32'(XOFF_CHAR));
        await(9, 1'b1);
        wr(REG_DATA, 32'h42);
        repeat (600) @(posedge sys_clk_in);
        rchk(REG_STATUS, 32'h1, 32'h0);
        wr(REG_LINE, 32'h01);
        await(0, 1'b1);
        rchk(REG_DATA, '1, 32'h42);
        wr(REG_LINE, 32'h189);
        n = 0;
        repeat (250) @(posedge sys_clk_in) n += ref_tick_out;
        chk(32'(n > 10 && n < 14), 32'h1);
        await(ST_BRK, 1'b1);
        wr(REG_LINE, 32'h01);
        wr(REG_STATUS, 32'hC);
        rchk(REG_STATUS, 32'h4, 32'h0);
        @(posedge sys_clk_in);
        ext_reset_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        ext_reset_n_in <= 1'b1;
        rchk(REG_BAUD, '1, 32'h8);
        conclude();
    end
endmodule // bridge_uart_core_bench
`default_nettype wire
